// [tcf_defs.vh]
// Purpose: constants for the command-frame interpreter
// Assumes: included by tcf_cmd_frames.v; byte offsets are frame offsets from byte 0
// Notes:   codes other than read and write are local choices
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH

// frame header layout
`define TCF_HDR_BYTES     32'd64
`define TCF_OFS_PRE_HI    6'h00
`define TCF_OFS_PRE_LO    6'h01
`define TCF_OFS_VER       6'h02
`define TCF_OFS_CMD       6'h03
`define TCF_OFS_SUB       6'h04
`define TCF_OFS_STATUS    6'h05
`define TCF_OFS_FLAGS     6'h06
`define TCF_OFS_LEN       6'h08
`define TCF_OFS_ADDR      6'h0c
`define TCF_OFS_DCRC      6'h3a
`define TCF_OFS_HCRC      6'h3e
`define TCF_OFS_HCRC_LAST 6'h3d
`define TCF_OFS_LAST      6'h3f

// fixed field values
`define TCF_PREAMBLE      16'ha1ec
`define TCF_PROTO_REV     8'h03
`define TCF_FLAG_NO_DCRC  0

// command codes
`define TCF_CMD_READ      8'h03
`define TCF_CMD_WRITE     8'h04
`define TCF_CMD_RESET     8'h05
`define TCF_CMD_FLASH     8'h06
`define TCF_CMD_ALIVE     8'h07

// result codes placed at the status byte of each response
`define TCF_ST_OK         8'h00
`define TCF_ST_BAD_HDR    8'h01
`define TCF_ST_BAD_CMD    8'h02
`define TCF_ST_BAD_LEN    8'h03
`define TCF_ST_BAD_DCRC   8'h04

// checksum generators and start values
`define TCF_CRC16_POLY    16'h1021
`define TCF_CRC16_INIT    16'h0000
`define TCF_CRC32_POLY    32'h04c11db7
`define TCF_CRC32_INIT    32'h0fffffff

// network settings and their register addresses
`define TCF_NET_PORT      16'h2711
`define TCF_NET_IP_RST    32'hc0a8000a
`define TCF_NET_MASK_RST  32'hffffff00
`define TCF_REG_IP_HI     16'h0010
`define TCF_REG_IP_LO     16'h0011
`define TCF_REG_MASK_HI   16'h0012
`define TCF_REG_MASK_LO   16'h0013

// idle timeout
`define TCF_IDLE_MS       3000
`define TCF_CLK_KHZ       10000

`endif

// [tcf_regmem.v]
// Purpose: register storage of 16-bit words behind the command interpreter
// Assumes: one write port and one read port on the same clock
// Notes:   read data appear one clock after the address, from a register
module tcf_regmem #(
  parameter AW = 8,                      // address bits kept
  parameter DW = 16                      // word width
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];        // storage array, no reset value

  // write port: array cells carry no reset, software sets them
  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {DW{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // tcf_regmem

// [tcf_cmd_frames.v]
// Purpose: parse control command frames from a TCP byte stream and answer each one
// Assumes: a TCP stack outside delivers and takes bytes in order with valid/ready
// Notes:   registers are 16-bit words held in tcf_regmem
// Summary of operation
// [RULE_01] frame starts with 16-bit preamble, high byte first
// [RULE_02] byte two holds protocol version three
// [RULE_03] byte three is command; three means read
// [RULE_04] host gives even byte count at offset eight
// [RULE_05] register count is length halved, 16-bit registers
// [RULE_06] start address at offset twelve, consecutive access
// [RULE_07] read command data checksum field is zero
// [RULE_08] header checksum covers bytes two through 0x3d
// [RULE_09] header checksum is CRC-CCITT, start zero
// [RULE_10] payload checksum is CRC-32, documented start value
// [RULE_11] every command gets exactly one response frame
// [RULE_12] read returns consecutive register contents
// [RULE_13] write updates consecutive registers
// [RULE_14] reset command reboots the module
// [RULE_15] flash update streams payload to chosen target
// [RULE_16] host sends keep-alive within two seconds
// [RULE_17] idle timeout closes connection, await new one
// [RULE_18] listen on port 10001, default address and mask
// [RULE_19] network setting writes apply at reconnect only
// [RULE_20] read response length reports bytes returned
// [RULE_21] read data at 0x40, words high byte first
// [RULE_22] bad preamble, version or checksum: report, no action; a bad data checksum is reported after write or flash bytes went out
`include "tcf_defs.vh"
module tcf_cmd_frames #(
  parameter AW      = 8,                                   // register address bits kept
  parameter IDLE_CYC = `TCF_IDLE_MS * `TCF_CLK_KHZ         // idle cycles before close
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // connection status from the TCP stack
  input  wire        conn_open,
  output reg         conn_close,
  // received bytes
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  output wire        rx_ready,
  // response bytes
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  input  wire        tx_ready,
  // flash update stream
  output reg         flash_start,
  output reg  [7:0]  flash_target,
  output reg         flash_valid,
  output reg  [7:0]  flash_data,
  output reg         flash_last,
  input  wire        flash_ready,
  // module reboot request
  output reg         sys_reset_req,
  // network settings in force
  output reg  [31:0] net_ip,
  output reg  [31:0] net_mask,
  output wire [15:0] listen_port
);

  // states
  localparam S_HDR  = 3'd0;                // collecting header bytes
  localparam S_CHK  = 3'd1;                // judging the header
  localparam S_PAY  = 3'd2;                // taking payload bytes
  localparam S_PCHK = 3'd3;                // judging the payload checksum
  localparam S_CALC = 3'd4;                // checksum pass over read data
  localparam S_TX   = 3'd5;                // sending the response
  localparam S_END  = 3'd6;                // after the response
  localparam [15:0] PRE = `TCF_PREAMBLE;   // preamble split into bytes below

  reg [2:0]  state;                        // frame state
  reg [31:0] cnt;                          // byte position, in and out
  reg [15:0] pre;                          // received preamble
  reg [7:0]  proto_rev_byte;               // received version
  reg [7:0]  cmd;                          // received command
  reg [7:0]  secondary_opcode;             // received sub command
  reg [15:0] flags;                        // received flags
  reg [31:0] len;                          // received length
  reg [15:0] start_reg_addr;               // received start address
  reg [31:0] payload_checksum;             // received data checksum
  reg [15:0] header_checksum;              // received header checksum
  reg [15:0] crc16;                        // running header checksum
  reg [31:0] crc32;                        // running data checksum
  reg [31:0] rsp_len;                      // length field of the response
  reg [7:0]  status;                       // result code of the response
  reg [31:0] widx;                         // word index within the access
  reg        rd_ph;                        // read address presented, data next
  reg [7:0]  wr_hi;                        // high byte of a word being written
  reg [31:0] idle;                         // cycles since last command
  reg        conn_prev;                    // conn_open one clock ago
  reg [31:0] pend_ip;                      // ip setting waiting for reconnect
  reg [31:0] pend_mask;                    // mask setting waiting for reconnect
  reg        we;                           // register write strobe
  reg [15:0] wdata;                        // register write data
  reg [15:0] waddr;                        // register write address
  reg [7:0]  hb;                           // next response byte
  wire [15:0] rdata;                       // register read data
  wire        rx_take;                     // byte accepted this clock
  wire        slot;                        // output stage free
  wire [15:0] raddr;                       // register read address
  wire        hdr_ok;                      // header passes all checks

  // one bit at a time, msb first, no final inversion
  function [15:0] f_crc16;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    begin
      f_crc16 = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (f_crc16[15] ^ d[i]) begin
          f_crc16 = {f_crc16[14:0], 1'b0} ^ `TCF_CRC16_POLY;
        end else begin
          f_crc16 = {f_crc16[14:0], 1'b0};
        end
      end
    end
  endfunction

  // same scheme for the wide data checksum
  function [31:0] f_crc32;
    input [31:0] c;
    input [7:0]  d;
    integer i;
    begin
      f_crc32 = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (f_crc32[31] ^ d[i]) begin
          f_crc32 = {f_crc32[30:0], 1'b0} ^ `TCF_CRC32_POLY;
        end else begin
          f_crc32 = {f_crc32[30:0], 1'b0};
        end
      end
    end
  endfunction

  assign listen_port = `TCF_NET_PORT;                      // [RULE_18]
  assign rx_take  = rx_valid && rx_ready;
  assign slot     = !tx_valid || tx_ready;
  assign raddr    = start_reg_addr + widx[15:0];           // [RULE_06]
  // version, preamble and checksum must all agree
  assign hdr_ok   = (pre == `TCF_PREAMBLE) && (proto_rev_byte == `TCF_PROTO_REV) &&
                    (crc16 == header_checksum);            // [RULE_01] [RULE_02] [RULE_08]
  // bytes are taken only while parsing; flash sink can stall the payload
  assign rx_ready = conn_open && ((state == S_HDR) ||
                    ((state == S_PAY) && ((cmd != `TCF_CMD_FLASH) || flash_ready)));

  tcf_regmem #(
    .AW    (AW),
    .DW    (16)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .we      (we),
    .waddr   (waddr[AW-1:0]),
    .wdata   (wdata),
    .raddr   (raddr[AW-1:0]),
    .rdata   (rdata)
  );

  // response header byte for the current output position
  always @* begin
    hb = 8'h00;
    case (cnt[5:0])
      `TCF_OFS_PRE_HI:     hb = PRE[15:8];                  // [RULE_01]
      `TCF_OFS_PRE_LO:     hb = PRE[7:0];
      `TCF_OFS_VER:        hb = `TCF_PROTO_REV;             // [RULE_02]
      `TCF_OFS_CMD:        hb = cmd;                        // echoes the command
      `TCF_OFS_SUB:        hb = secondary_opcode;
      `TCF_OFS_STATUS:     hb = status;
      6'h08:               hb = rsp_len[31:24];             // [RULE_20]
      6'h09:               hb = rsp_len[23:16];
      6'h0a:               hb = rsp_len[15:8];
      6'h0b:               hb = rsp_len[7:0];
      `TCF_OFS_ADDR:       hb = start_reg_addr[15:8];       // [RULE_06]
      6'h0d:               hb = start_reg_addr[7:0];
      `TCF_OFS_DCRC:       hb = crc32[31:24];
      6'h3b:               hb = crc32[23:16];
      6'h3c:               hb = crc32[15:8];
      `TCF_OFS_HCRC_LAST:  hb = crc32[7:0];
      `TCF_OFS_HCRC:       hb = crc16[15:8];                // [RULE_08]
      `TCF_OFS_LAST:       hb = crc16[7:0];
      default:             hb = 8'h00;                      // reserved and spare bytes
    endcase
  end

  // idle watchdog and network settings hand-over
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle       <= 32'd0;
      conn_close <= 1'b0;
      conn_prev  <= 1'b0;
      net_ip     <= `TCF_NET_IP_RST;                       // [RULE_18]
      net_mask   <= `TCF_NET_MASK_RST;
    end else begin
      conn_prev  <= conn_open;
      conn_close <= 1'b0;
      // new settings only when a fresh connection comes up
      if (conn_open && !conn_prev) begin
        net_ip   <= pend_ip;                               // [RULE_19]
        net_mask <= pend_mask;
      end
      if (!conn_open || (state == S_CHK)) begin
        idle <= 32'd0;                                     // any whole command re-arms
      end else if (idle == IDLE_CYC - 1) begin
        idle       <= 32'd0;
        conn_close <= 1'b1;                                // [RULE_17]
      end else begin
        idle <= idle + 32'd1;
      end
    end
  end

  // frame engine
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state            <= S_HDR;
      cnt              <= 32'd0;
      pre              <= 16'h0000;
      proto_rev_byte   <= 8'h00;
      cmd              <= 8'h00;
      secondary_opcode <= 8'h00;
      flags            <= 16'h0000;
      len              <= 32'd0;
      start_reg_addr   <= 16'h0000;
      payload_checksum <= 32'd0;
      header_checksum  <= 16'h0000;
      crc16            <= `TCF_CRC16_INIT;
      crc32            <= `TCF_CRC32_INIT;
      rsp_len          <= 32'd0;
      status           <= `TCF_ST_OK;
      widx             <= 32'd0;
      rd_ph            <= 1'b0;
      wr_hi            <= 8'h00;
      we               <= 1'b0;
      wdata            <= 16'h0000;
      waddr            <= 16'h0000;
      pend_ip          <= `TCF_NET_IP_RST;
      pend_mask        <= `TCF_NET_MASK_RST;
      tx_valid         <= 1'b0;
      tx_data          <= 8'h00;
      flash_start      <= 1'b0;
      flash_target     <= 8'h00;
      flash_valid      <= 1'b0;
      flash_data       <= 8'h00;
      flash_last       <= 1'b0;
      sys_reset_req    <= 1'b0;
    end else begin
      we            <= 1'b0;
      flash_start   <= 1'b0;
      flash_valid   <= 1'b0;
      flash_last    <= 1'b0;
      sys_reset_req <= 1'b0;
      if (!conn_open || conn_close) begin
        // dropped or timed-out link abandons the frame in flight
        state    <= S_HDR;
        cnt      <= 32'd0;
        crc16    <= `TCF_CRC16_INIT;
        tx_valid <= 1'b0;
      end else begin
        case (state)
          S_HDR: begin
            if (rx_take) begin
              cnt <= cnt + 32'd1;
              if (cnt < 32'd2) pre <= {pre[7:0], rx_data};                 // [RULE_01]
              if (cnt[5:0] == `TCF_OFS_VER) proto_rev_byte <= rx_data;     // [RULE_02]
              if (cnt[5:0] == `TCF_OFS_CMD) cmd <= rx_data;                // [RULE_03]
              if (cnt[5:0] == `TCF_OFS_SUB) secondary_opcode <= rx_data;
              if (cnt[5:1] == 5'h03) flags <= {flags[7:0], rx_data};
              if (cnt[5:2] == 4'h2) len <= {len[23:0], rx_data};           // [RULE_04]
              if (cnt[5:1] == 5'h06) start_reg_addr <= {start_reg_addr[7:0], rx_data};
              if ((cnt >= 32'h3a) && (cnt <= 32'h3d)) begin
                payload_checksum <= {payload_checksum[23:0], rx_data};
              end
              if (cnt >= 32'h3e) header_checksum <= {header_checksum[7:0], rx_data};
              if ((cnt >= 32'd2) && (cnt <= 32'h3d)) begin
                crc16 <= f_crc16(crc16, rx_data);                          // [RULE_09]
              end
              if (cnt == `TCF_HDR_BYTES - 32'd1) state <= S_CHK;
            end
          end
          S_CHK: begin
            // one answer per frame whatever the verdict
            cnt     <= 32'd0;                                              // [RULE_11]
            widx    <= 32'd0;
            rd_ph   <= 1'b0;
            rsp_len <= 32'd0;
            crc32   <= `TCF_CRC32_INIT;                                    // [RULE_10]
            status  <= `TCF_ST_OK;
            state   <= S_TX;
            if (!hdr_ok) begin
              status <= `TCF_ST_BAD_HDR;                                   // [RULE_22]
            end else begin
              case (cmd)
                `TCF_CMD_READ: begin
                  if (len[0]) begin
                    status <= `TCF_ST_BAD_LEN;                             // [RULE_04]
                  end else if (payload_checksum != 32'd0) begin
                    status <= `TCF_ST_BAD_DCRC;                            // [RULE_07]
                  end else begin
                    rsp_len <= len;                                        // [RULE_20]
                    state   <= S_CALC;                                     // [RULE_12]
                  end
                end
                `TCF_CMD_WRITE: begin
                  waddr <= start_reg_addr;
                  if (len[0]) status <= `TCF_ST_BAD_LEN;
                  else if (len != 32'd0) state <= S_PAY;                   // [RULE_13]
                end
                `TCF_CMD_FLASH: begin
                  flash_start  <= 1'b1;                                    // [RULE_15]
                  flash_target <= secondary_opcode;
                  if (len != 32'd0) state <= S_PAY;
                end
                `TCF_CMD_RESET: status <= `TCF_ST_OK;                      // [RULE_14]
                `TCF_CMD_ALIVE: status <= `TCF_ST_OK;                      // [RULE_16]
                default:        status <= `TCF_ST_BAD_CMD;
              endcase
            end
          end
          S_PAY: begin
            if (rx_take) begin
              cnt   <= cnt + 32'd1;
              crc32 <= f_crc32(crc32, rx_data);                            // [RULE_10]
              if (cmd == `TCF_CMD_FLASH) begin
                flash_valid <= 1'b1;                                       // [RULE_15]
                flash_data  <= rx_data;
                flash_last  <= (cnt == len - 32'd1);
              end else if (!cnt[0]) begin
                wr_hi <= rx_data;                                          // [RULE_05]
              end else begin
                // word complete: write it, stepping the address first for every word after the first
                we    <= 1'b1;                                             // [RULE_13]
                wdata <= {wr_hi, rx_data};
                if (cnt != 32'd1) waddr <= waddr + 16'd1;                  // [RULE_06]
                if (waddr + {15'd0, cnt != 32'd1} == `TCF_REG_IP_HI)
                  pend_ip[31:16] <= {wr_hi, rx_data};                      // [RULE_19]
                if (waddr + {15'd0, cnt != 32'd1} == `TCF_REG_IP_LO)
                  pend_ip[15:0] <= {wr_hi, rx_data};
                if (waddr + {15'd0, cnt != 32'd1} == `TCF_REG_MASK_HI)
                  pend_mask[31:16] <= {wr_hi, rx_data};
                if (waddr + {15'd0, cnt != 32'd1} == `TCF_REG_MASK_LO)
                  pend_mask[15:0] <= {wr_hi, rx_data};
              end
              if (cnt == len - 32'd1) state <= S_PCHK;
            end
          end
          S_PCHK: begin
            // writes went out as words arrived, so a bad sum is only reported
            if (!flags[`TCF_FLAG_NO_DCRC] && (crc32 != payload_checksum))
              status <= `TCF_ST_BAD_DCRC;
            crc32 <= 32'd0;
            cnt   <= 32'd0;
            state <= S_TX;
          end
          S_CALC: begin
            // sum the read data first since its checksum precedes it
            if (widx == {1'b0, len[31:1]}) begin                           // [RULE_05]
              widx  <= 32'd0;
              state <= S_TX;
            end else if (!rd_ph) begin
              rd_ph <= 1'b1;
            end else begin
              crc32 <= f_crc32(f_crc32(crc32, rdata[15:8]), rdata[7:0]);   // [RULE_10]
              widx  <= widx + 32'd1;
              rd_ph <= 1'b0;
            end
          end
          S_TX: begin
            if (slot) begin
              if (cnt < `TCF_HDR_BYTES) begin
                tx_valid <= 1'b1;
                tx_data  <= hb;
                cnt      <= cnt + 32'd1;
                if ((cnt >= 32'd2) && (cnt <= 32'h3d)) crc16 <= f_crc16(crc16, hb);
                if (cnt == 32'd0) crc16 <= `TCF_CRC16_INIT;                // [RULE_09]
              end else if ((cnt - `TCF_HDR_BYTES) < rsp_len) begin
                if (!cnt[0] && !rd_ph) begin
                  rd_ph    <= 1'b1;                                        // wait for read data
                  tx_valid <= 1'b0;
                end else begin
                  tx_valid <= 1'b1;                                        // [RULE_21]
                  tx_data  <= cnt[0] ? rdata[7:0] : rdata[15:8];
                  cnt      <= cnt + 32'd1;
                  if (cnt[0]) begin
                    rd_ph <= 1'b0;
                    widx  <= widx + 32'd1;
                  end
                end
              end else begin
                tx_valid <= 1'b0;
                state    <= S_END;
              end
            end
          end
          S_END: begin
            // reboot only after the answer has left
            if ((cmd == `TCF_CMD_RESET) && (status == `TCF_ST_OK))
              sys_reset_req <= 1'b1;                                       // [RULE_14]
            cnt   <= 32'd0;
            crc16 <= `TCF_CRC16_INIT;
            state <= S_HDR;
          end
          default: state <= S_HDR;
        endcase
      end
    end
  end

endmodule // tcf_cmd_frames

// [tcf_host_model.sv]
// Purpose: host side, collects response bytes
// Assumes: bytes taken on rising edges, valid and ready high
// Notes:   slow mode stalls tx_ready one cycle in four
module tcf_host_model (
  // clock
  input  wire       clk_sys,
  // response stream from the block
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output logic      tx_ready,
  // flash sink handshake
  output logic      flash_ready,
  // pacing choice
  input  wire       slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp [0:255];                // captured response bytes
  int         n = 0;                      // bytes captured, cleared by the bench
  logic [1:0] ph = 2'h0;                  // stall phase
  // pacing changes off the sampling edge
  always @(negedge clk_sys) begin
    ph          <= ph + 2'h1;
    tx_ready    <= !slow || (ph != 2'h3);
    flash_ready <= !slow || (ph != 2'h1);
  end
  // one byte per accepted cycle
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      rsp[n] <= tx_data;
      n      <= n + 1;
    end
  end
endmodule // tcf_host_model

// [tcf_cmd_frames_asserts.sv]
// Purpose: port checks of the frame interpreter
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into the interpreter module tcf_cmd_frames
module tcf_cmd_frames_asserts (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // watched ports
  input wire        conn_open,
  input wire        conn_close,
  input wire        rx_ready,
  input wire        tx_valid,
  input wire [7:0]  tx_data,
  input wire        tx_ready,
  input wire        flash_start,
  input wire        flash_valid,
  input wire        flash_last,
  input wire        sys_reset_req,
  input wire [15:0] listen_port
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_port; listen_port == 16'h2711; endproperty
  a_port: assert property (p_port) else $error("listen port wrong");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("tx byte dropped");
  property p_busy; tx_valid |-> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("rx open while answering");
  property p_shut; !conn_open |-> !rx_ready; endproperty
  a_shut: assert property (p_shut) else $error("rx open without link");
  property p_cls; conn_close |=> !conn_close ##1 !conn_close; endproperty
  a_cls: assert property (p_cls) else $error("close not a pulse");
  property p_idle; !conn_open [*2] |-> !conn_close; endproperty
  a_idle: assert property (p_idle) else $error("close while closed");
  property p_rst; sys_reset_req |=> !sys_reset_req; endproperty
  a_rst: assert property (p_rst) else $error("reboot not a pulse");
  property p_last; flash_last |-> flash_valid; endproperty
  a_last: assert property (p_last) else $error("last without byte");
  property p_fst; flash_start |=> !flash_start; endproperty
  a_fst: assert property (p_fst) else $error("flash start not a pulse");
endmodule // tcf_cmd_frames_asserts
bind tcf_cmd_frames tcf_cmd_frames_asserts u_chk (.*);

// [testbench.sv]
// Purpose: self-checking bench for the command-frame interpreter
// Assumes: inputs change on falling edges, host model paces responses
// Notes:   short idle limit keeps the timeout case brief
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, conn_open = 0, rx_valid = 0, slow = 1;
  logic [7:0] rx_data = 0, h [0:63], p [0:3], tx_data, flash_target, flash_data;
  logic tx_valid, tx_ready, flash_ready, conn_close, flash_start, flash_valid;
  logic flash_last, sys_reset_req, rx_ready;
  logic [31:0] net_ip, net_mask, c;
  logic [15:0] listen_port;
  int num_errors = 0, cmp_count = 0, cyc = 0, i;
  always #50 clk_sys = ~clk_sys;
  tcf_cmd_frames #(.AW(8), .IDLE_CYC(400)) u_dut (.*);
  tcf_host_model u_host (.*);
  // msb-first crc step for either checksum width, no reflection
  function automatic [31:0] crc(input [31:0] v, input [7:0] d, input [31:0] g, input int w);
    for (int k = 7; k >= 0; k--) v = ((v << 1) ^ ((v[w-1] ^ d[k]) ? g : 0));
    return (w == 16) ? (v & 32'hffff) : v;
  endfunction
  // one byte, held until taken
  task snd(input [7:0] b);
    rx_valid = 1; rx_data = b;
    while (rx_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  // command frame; payload only for writes
  task frm(input [7:0] pre, cmd, input [31:0] len, input [15:0] ad, input [31:0] dc);
    u_host.n = 0; c = 0;
    for (i = 0; i < 64; i++) h[i] = 8'h00;
    {h[0], h[1], h[2], h[3]} = {pre, 8'hec, 8'h03, cmd};
    {h[8], h[9], h[10], h[11], h[12], h[13]} = {len, ad};
    {h[58], h[59], h[60], h[61]} = dc;
    for (i = 2; i < 62; i++) c = crc(c, h[i], 32'h1021, 16);
    {h[62], h[63]} = c[15:0];
    for (i = 0; i < 64; i++) snd(h[i]);
    for (i = 0; i < len && cmd == 8'h04; i++) snd(p[i]);
    rx_valid = 0;
  endtask
  // wait for the answer, judge its header
  task rsp(input [7:0] cmd, st, input [31:0] len);
    for (i = 0; i < 3000 && u_host.n < 64 + len; i++) @(negedge clk_sys);
    repeat (4) @(negedge clk_sys);
    `CHK(u_host.n, 64 + len)
    `CHK({u_host.rsp[0], u_host.rsp[1], u_host.rsp[3]}, {16'ha1ec, cmd})
    `CHK({u_host.rsp[5], u_host.rsp[8], u_host.rsp[9], u_host.rsp[10], u_host.rsp[11]},
         {st, len})
    c = 0;
    for (i = 2; i < 62; i++) c = crc(c, u_host.rsp[i], 32'h1021, 16);
    `CHK({u_host.rsp[62], u_host.rsp[63]}, c[15:0])
  endtask
  // two words written, read back
  task t_rw;
    {p[0], p[1], p[2], p[3]} = 32'h1234beef; c = 32'h0fffffff;
    for (i = 0; i < 4; i++) c = crc(c, p[i], 32'h04c11db7, 32);
    frm(8'ha1, 8'h04, 4, 16'h0020, c); rsp(8'h04, 8'h00, 0);
    frm(8'ha1, 8'h03, 4, 16'h0020, 0); rsp(8'h03, 8'h00, 4);
    `CHK({u_host.rsp[64], u_host.rsp[65], u_host.rsp[66], u_host.rsp[67]}, 32'h1234beef)
    c = 32'h0fffffff;
    for (i = 64; i < 68; i++) c = crc(c, u_host.rsp[i], 32'h04c11db7, 32);
    `CHK({u_host.rsp[58], u_host.rsp[59], u_host.rsp[60], u_host.rsp[61]}, c)
    $display("test rw done");
  endtask
  // refused frames: bad preamble, odd length, unknown code
  task t_bad;
    frm(8'ha0, 8'h03, 2, 16'h0020, 0); rsp(8'h03, 8'h01, 0);
    frm(8'ha1, 8'h03, 3, 16'h0020, 0); rsp(8'h03, 8'h03, 0);
    frm(8'ha1, 8'h09, 0, 16'h0000, 0); rsp(8'h09, 8'h02, 0);
    $display("test bad done");
  endtask
  // net write at reconnect, reboot, idle close
  task t_net;
    {p[0], p[1], p[2], p[3]} = 32'hc0a80014; c = 32'h0fffffff;
    for (i = 0; i < 4; i++) c = crc(c, p[i], 32'h04c11db7, 32);
    frm(8'ha1, 8'h04, 4, 16'h0010, c); rsp(8'h04, 8'h00, 0);
    `CHK(net_ip, 32'hc0a8000a)
    conn_open = 0; @(negedge clk_sys); conn_open = 1; repeat (3) @(negedge clk_sys);
    `CHK(net_ip, 32'hc0a80014)
    frm(8'ha1, 8'h05, 0, 16'h0000, 0);
    for (i = 0; i < 200 && sys_reset_req !== 1'b1; i++) @(negedge clk_sys);
    `CHK(sys_reset_req, 1'b1)
    rsp(8'h05, 8'h00, 0);
    for (i = 0; i < 500 && conn_close !== 1'b1; i++) @(negedge clk_sys);
    `CHK(conn_close, 1'b1)
    $display("test net done");
  endtask
  // verdict and end of run
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog for a hang
  always @(posedge clk_sys) if (++cyc > 30000) begin num_errors++; complete_run; end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1; conn_open = 1;
    `CHK({listen_port, net_mask}, {16'h2711, 32'hffffff00})
    @(negedge clk_sys);
    t_rw; t_bad; t_net;
    complete_run;
  end
endmodule // testbench
